/* mcad_regs.svh */
// Field codes, selector codes and timing figures of the microcoded datapath
`ifndef MCAD_REGS_SVH
`define MCAD_REGS_SVH

`define MCAD_CYCLE_NS 170
`define MCAD_CLOCK_NS 10

`define MCAD_BS_READ_REG 3'h0
`define MCAD_BS_LOAD_REG 3'h1
`define MCAD_BS_NONE 3'h2
`define MCAD_BS_TASK_A 3'h3
`define MCAD_BS_TASK_B 3'h4
`define MCAD_BS_MEM_DATA 3'h5
`define MCAD_BS_POINTER 3'h6
`define MCAD_BS_DISPLACE 3'h7

`define MCAD_F1_LOAD_MAR 4'h1
`define MCAD_F1_SHIFT_LEFT 4'h4
`define MCAD_F1_SHIFT_RIGHT 4'h5
`define MCAD_F1_ROTATE_8 4'h6
`define MCAD_F1_CONSTANT 4'h7
`define MCAD_F2_MEM_WRITE 4'h6
`define MCAD_F2_CONSTANT 4'h7
`define MCAD_F2_SRC_CELL 4'he
`define MCAD_F2_DST_CELL 4'hb

`define MCAD_T_FROM_ALU_MASK 16'h3864
`define MCAD_RESET_WORD 16'h0000

`endif

/* mcad_pkg.sv */
// Types shared by the microcoded datapath
package mcad_pkg;

    typedef struct packed {
        logic [0:4] regCellSelector;
        logic [0:3] aluFuncField;
        logic [0:2] busSourceField;
        logic [0:3] funcOneField;
        logic [0:3] funcTwoField;
        logic loadOperand;
        logic loadShiftShadow;
        logic [0:9] nextAddr;
    } mcad_micro_t;

    typedef enum logic [1:0] {
        CARRY_ZERO,
        CARRY_ONE,
        CARRY_SKIP
    } mcad_carry_t;

    typedef struct packed {
        logic [3:0] aluSelectLines;
        logic logicMode;
        mcad_carry_t carryIn;
    } mcad_alu_ctrl_t;

    typedef struct packed {
        logic [0:31][0:15] regFile;
        logic [0:31][0:15] scratchFile;
        logic [0:15] operand;
        logic [0:15] shiftSrc;
        logic [0:15] shadow;
        logic [0:15] memAddrReg;
        logic [0:15] instrHoldReg;
        logic [0:15] memWriteData;
        logic memStart;
        logic memWrite;
        logic savedAluCarry;
        logic emuCarry;
    } mcad_state_t;

endpackage

/* mcad_datapath.sv */
// Arithmetic section of the microprogrammed processor: fields, registers, ALU, shifter, bus
`timescale 1ns/10ps
`include "mcad_regs.svh"

// Summary of operation
// [RULE1] Split microword into its eight fields
// [RULE2] Bit zero is the most significant bit
// [RULE3] One clock, one cycle per microinstruction
// [RULE4] Datapath shared by sixteen tasks, no overhead
// [RULE5] Two 32x16 files plus five registers, bus
// [RULE6] ALU result loads shift-source, shadow, address
// [RULE7] Shift left, right, rotate eight, special modes
// [RULE8] 256-word constant memory drives the bus
// [RULE9] State holds steady; paths compute combinationally
// [RULE10] All selected loads happen together at edge
// [RULE11] Microcode never reads and loads cell together
// [RULE12] Cell selector picks cell or constant word
// [RULE13] Low cell bits replaceable from instruction register
// [RULE14] Function field mapped to select, mode, carry
// [RULE15] Sixteen function codes, two undefined
// [RULE16] Bus is A, operand is B input
// [RULE17] Marked functions load operand from ALU
// [RULE18] Carry out zero in logical mode
// [RULE19] Function 13B carries in the skip bit
// [RULE20] Multiple sources AND; no source reads ones
// [RULE21] Constant address is selector then bus source
// [RULE22] Saved carry follows last shift-source load
// [RULE23] Every load on one edge; contents undefined
// [RULE24] Undefined functions give unchecked result, carry
module mcad_datapath
    import mcad_pkg::*;
#(
    parameter int WORD_W = 16,
    parameter int CELLS = 32,
    parameter int TASKS = 16,
    parameter logic [15:0] T_FROM_ALU = `MCAD_T_FROM_ALU_MASK,
    parameter logic [0:255][0:15] CONST_TABLE = {128{16'hffff, 16'h0001}}
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire mcad_micro_t microWord,
    input wire logic [0:3] taskId,
    input wire logic skipBit,
    input wire logic [0:15] memData,
    input wire logic [0:15] taskSourceData,
    input wire logic [0:3] pointerBits,
    input wire logic displaceSignExt,
    input wire logic instrLoad,
    input wire logic scratchRead,
    input wire logic scratchWrite,
    input wire logic novelShift,
    input wire logic magicShift,
    output logic [0:15] busValue,
    output logic [0:15] aluResult,
    output logic aluCarryOut,
    output logic [0:15] shifterOut,
    output logic [0:9] nextAddr,
    output logic [0:15] operandReg,
    output logic [0:15] shiftSrcReg,
    output logic [0:15] shadowReg,
    output logic [0:15] memAddrReg,
    output logic [0:15] instrHoldReg,
    output logic memStart,
    output logic memWrite,
    output logic [0:15] memWriteData,
    output logic savedAluCarry
);

    // Mapping PROM from function field to select lines, mode and carry kind
    function automatic mcad_alu_ctrl_t mapAluFunc(input logic [0:3] code);
        mcad_alu_ctrl_t c;
        c = '{aluSelectLines: 4'hf, logicMode: 1'b1, carryIn: CARRY_ZERO};
        unique case (code)
            4'h0: c = '{4'hf, 1'b1, CARRY_ZERO};
            4'h1: c = '{4'ha, 1'b1, CARRY_ZERO};
            4'h2: c = '{4'he, 1'b1, CARRY_ZERO};
            4'h3: c = '{4'hb, 1'b1, CARRY_ZERO};
            4'h4: c = '{4'h6, 1'b1, CARRY_ZERO};
            4'h5: c = '{4'h0, 1'b0, CARRY_ONE};
            4'h6: c = '{4'hf, 1'b0, CARRY_ZERO};
            4'h7: c = '{4'h9, 1'b0, CARRY_ZERO};
            4'h8: c = '{4'h6, 1'b0, CARRY_ONE};
            4'h9: c = '{4'h6, 1'b0, CARRY_ZERO};
            4'ha: c = '{4'h9, 1'b0, CARRY_ONE};
            4'hb: c = '{4'h0, 1'b0, CARRY_SKIP}; // [RULE19]
            4'hc: c = '{4'hb, 1'b1, CARRY_ZERO};
            4'hd: c = '{4'h7, 1'b1, CARRY_ZERO};
            // Undefined codes fall back to the pass-A mapping
            default: c = '{4'hf, 1'b1, CARRY_ZERO}; // [RULE24]
        endcase
        return c; // [RULE14] [RULE15]
    endfunction

    // Only the select codes the mapping can reach are built
    function automatic logic [16:0] runAlu(
        input logic [0:15] a,
        input logic [0:15] b,
        input mcad_alu_ctrl_t c,
        input logic skip
    );
        logic [16:0] r;
        logic cin;
        r = 17'h00000;
        cin = (c.carryIn == CARRY_ONE) || (c.carryIn == CARRY_SKIP && skip);
        if (c.logicMode) begin
            unique case (c.aluSelectLines)
                4'ha: r = {1'b0, b};
                4'he: r = {1'b0, a | b};
                4'hb: r = {1'b0, a & b};
                4'h6: r = {1'b0, a ^ b};
                4'h7: r = {1'b0, a & ~b};
                default: r = {1'b0, a};
            endcase // [RULE18]
        end else begin
            unique case (c.aluSelectLines)
                4'hf: r = {1'b0, a} + 17'h0ffff + {16'h0000, cin};
                4'h9: r = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
                4'h6: r = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
                default: r = {1'b0, a} + {16'h0000, cin};
            endcase
        end
        return r;
    endfunction

    // Shift helper; fill bits chosen by the caller keep the modes in one place
    function automatic logic [0:16] runShift(
        input logic [0:15] src,
        input logic [0:3] f1,
        input logic fillLeft,
        input logic fillRight
    );
        logic [0:16] r;
        r = {src, 1'b0};
        unique case (f1)
            `MCAD_F1_SHIFT_LEFT: r = {src[1:15], fillLeft, src[0]};
            `MCAD_F1_SHIFT_RIGHT: r = {fillRight, src[0:14], src[15]};
            `MCAD_F1_ROTATE_8: r = {src[8:15], src[0:7], 1'b0};
            default: r = {src, 1'b0};
        endcase
        return r; // [RULE7]
    endfunction

    mcad_state_t state_r;
    mcad_state_t state_nxt;
    mcad_alu_ctrl_t aluCtrl;
    logic [16:0] aluFull;
    logic [0:16] shiftFull;
    logic [0:4] cellAddr;
    logic [0:7] constAddr;
    logic constEnable;
    logic busDecodeOn;
    logic operandFromAlu;
    logic isShift;
    logic [0:15] displaceWord;

    // Cell address with emulator overrides on the low two bits
    always_comb begin
        cellAddr = microWord.regCellSelector;
        if (microWord.funcTwoField == `MCAD_F2_SRC_CELL) begin
            cellAddr = {microWord.regCellSelector[0:2], state_r.instrHoldReg[1:2]}; // [RULE13]
        end else if (microWord.funcTwoField == `MCAD_F2_DST_CELL) begin
            cellAddr = {microWord.regCellSelector[0:2], state_r.instrHoldReg[3:4]}; // [RULE13]
        end
    end

    // Constant address never takes the instruction register bits
    assign constAddr = {microWord.regCellSelector, microWord.busSourceField}; // [RULE21] [RULE12]
    assign busDecodeOn = (microWord.funcOneField != `MCAD_F1_CONSTANT)
        && (microWord.funcTwoField != `MCAD_F2_CONSTANT);
    assign constEnable = !busDecodeOn || microWord.busSourceField[0]; // [RULE8]
    assign displaceWord = {{8{displaceSignExt & state_r.instrHoldReg[8]}},
        state_r.instrHoldReg[8:15]};

    // Wired-AND bus built from the start-of-cycle register values only
    always_comb begin
        busValue = 16'hffff; // [RULE20]
        if (busDecodeOn) begin
            unique case (microWord.busSourceField)
                `MCAD_BS_READ_REG: busValue = state_r.regFile[cellAddr];
                // Forced to zero so a pass-operand function can run alongside
                `MCAD_BS_LOAD_REG: busValue = 16'h0000;
                `MCAD_BS_NONE: busValue = 16'hffff;
                `MCAD_BS_TASK_A: busValue = taskSourceData;
                `MCAD_BS_TASK_B: busValue = taskSourceData;
                `MCAD_BS_MEM_DATA: busValue = memData;
                `MCAD_BS_POINTER: busValue = {12'hfff, pointerBits};
                `MCAD_BS_DISPLACE: busValue = displaceWord;
            endcase
        end
        if (constEnable) begin
            busValue = busValue & CONST_TABLE[constAddr]; // [RULE20]
        end
        if (scratchRead) begin
            busValue = busValue & state_r.scratchFile[microWord.regCellSelector];
        end
    end // [RULE9]

    assign aluCtrl = mapAluFunc(microWord.aluFuncField);
    assign aluFull = runAlu(busValue, state_r.operand, aluCtrl, skipBit); // [RULE16]
    assign aluResult = aluFull[15:0];
    assign aluCarryOut = aluCtrl.logicMode ? 1'b0 : aluFull[16]; // [RULE18]
    assign isShift = (microWord.funcOneField == `MCAD_F1_SHIFT_LEFT)
        || (microWord.funcOneField == `MCAD_F1_SHIFT_RIGHT);

    // Double-length mode fills from the operand, novel mode through the emulator carry
    always_comb begin
        shiftFull = runShift(state_r.shiftSrc, microWord.funcOneField, 1'b0, 1'b0);
        if (magicShift) begin
            shiftFull = runShift(state_r.shiftSrc, microWord.funcOneField,
                state_r.operand[0], state_r.operand[15]); // [RULE7]
        end else if (novelShift) begin
            shiftFull = runShift(state_r.shiftSrc, microWord.funcOneField,
                state_r.emuCarry, state_r.emuCarry); // [RULE7]
        end
    end
    assign shifterOut = shiftFull[0:15];

    assign operandFromAlu = T_FROM_ALU[microWord.aluFuncField]; // [RULE17]
    assign nextAddr = microWord.nextAddr; // [RULE1]

    // Next state: every load is computed here and lands on one edge
    always_comb begin
        state_nxt = state_r;
        state_nxt.memStart = 1'b0;
        state_nxt.memWrite = 1'b0;
        if (microWord.loadOperand) begin
            state_nxt.operand = operandFromAlu ? aluResult : busValue; // [RULE17]
        end
        if (microWord.loadShiftShadow) begin
            state_nxt.shiftSrc = aluResult; // [RULE6]
            state_nxt.shadow = aluResult; // [RULE6]
            state_nxt.savedAluCarry = aluCarryOut; // [RULE22]
        end
        if (microWord.funcOneField == `MCAD_F1_LOAD_MAR) begin
            state_nxt.memAddrReg = aluResult; // [RULE6]
            state_nxt.memStart = 1'b1;
        end
        if (microWord.funcTwoField == `MCAD_F2_MEM_WRITE) begin
            state_nxt.memWriteData = busValue;
            state_nxt.memWrite = 1'b1;
        end
        if (busDecodeOn && microWord.busSourceField == `MCAD_BS_LOAD_REG) begin
            // Read port is unused in this cycle, so no same-cell hazard
            state_nxt.regFile[cellAddr] = shifterOut; // [RULE11] [RULE12]
        end
        if (novelShift && isShift) begin
            state_nxt.emuCarry = shiftFull[16]; // [RULE7]
        end
        if (instrLoad) begin
            state_nxt.instrHoldReg = busValue;
        end
        if (scratchWrite) begin
            state_nxt.scratchFile[microWord.regCellSelector] = state_r.shadow; // [RULE5]
        end
    end // [RULE10]

    // No per-task copies: any task's microword may follow any other's
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= '0; // [RULE23]
        end else begin
            state_r <= state_nxt; // [RULE3] [RULE4] [RULE10]
        end
    end

    assign operandReg = state_r.operand;
    assign shiftSrcReg = state_r.shiftSrc; // [RULE2]
    assign shadowReg = state_r.shadow;
    assign memAddrReg = state_r.memAddrReg;
    assign instrHoldReg = state_r.instrHoldReg;
    assign memStart = state_r.memStart;
    assign memWrite = state_r.memWrite;
    assign memWriteData = state_r.memWriteData;
    assign savedAluCarry = state_r.savedAluCarry;

endmodule // mcad_datapath

/* mcad_ctrl_store.sv */
// Control-store model standing in front of the datapath
`timescale 1ns/10ps
module mcad_ctrl_store
    import mcad_pkg::*;
(
    input wire mcad_micro_t wordReq,
    output mcad_micro_t microWord
);
    // Word is issued whole and held for the full cycle
    // Cell read and cell load use separate source codes, never both at once
    always_comb microWord = wordReq;
endmodule // mcad_ctrl_store

/* mcad_datapath_chk.sv */
// Port assertions for the microcoded datapath
`timescale 1ns/10ps
`include "mcad_regs.svh"
module mcad_datapath_chk
    import mcad_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire mcad_micro_t microWord,
    input wire logic skipBit,
    input wire logic scratchRead,
    input wire logic novelShift,
    input wire logic magicShift,
    input wire logic [0:15] busValue,
    input wire logic [0:15] aluResult,
    input wire logic aluCarryOut,
    input wire logic [0:15] shifterOut,
    input wire logic [0:9] nextAddr,
    input wire logic [0:15] operandReg,
    input wire logic [0:15] shiftSrcReg,
    input wire logic [0:15] shadowReg,
    input wire logic [0:15] memAddrReg,
    input wire logic memStart,
    input wire logic memWrite,
    input wire logic [0:15] memWriteData,
    input wire logic savedAluCarry
);
    localparam logic [15:0] TMASK = `MCAD_T_FROM_ALU_MASK;
    wire [0:3] alu_func_field = microWord.aluFuncField;
    wire [0:3] f1 = microWord.funcOneField;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_NEXT_ADDR: assert property (nextAddr == microWord.nextAddr)
        else $error("next address field not passed through");
    AST_ADD: assert property (alu_func_field == 4'h7 |-> aluResult == busValue + operandReg)
        else $error("sum of bus and operand wrong");
    AST_SUB: assert property (alu_func_field == 4'h8 |-> aluResult == busValue - operandReg)
        else $error("difference of bus and operand wrong");
    AST_SKIP: assert property (alu_func_field == 4'hb |-> aluResult == busValue + {15'h0000, skipBit})
        else $error("skip carry-in not applied");
    AST_LOGIC_CARRY: assert property (alu_func_field inside {[0:4], 4'hc, 4'hd} |-> !aluCarryOut)
        else $error("carry out set in logical mode");
    AST_SHIFT_LOAD: assert property (microWord.loadShiftShadow |=> shiftSrcReg == $past(aluResult)
        && shadowReg == $past(aluResult) && savedAluCarry == $past(aluCarryOut))
        else $error("shift-source, shadow or saved carry load wrong");
    AST_HOLD: assert property (!microWord.loadShiftShadow |=> $stable(shiftSrcReg) && $stable(savedAluCarry))
        else $error("state changed without a load");
    AST_ADDR_LOAD: assert property (f1 == 4'h1 |=> memAddrReg == $past(aluResult) && memStart)
        else $error("address register or start pulse wrong");
    AST_MEM_WRITE: assert property (microWord.funcTwoField == 4'h6 |=>
        memWrite && memWriteData == $past(busValue))
        else $error("memory write pulse or data wrong");
    AST_OPERAND: assert property (microWord.loadOperand |=>
        operandReg == ($past(TMASK[alu_func_field]) ? $past(aluResult) : $past(busValue)))
        else $error("operand register took the wrong source");
    AST_ROTATE: assert property (f1 == 4'h6 |-> shifterOut == {shiftSrcReg[8:15], shiftSrcReg[0:7]})
        else $error("rotate by eight wrong");
    AST_LEFT: assert property (f1 == 4'h4 && !novelShift && !magicShift |->
        shifterOut == {shiftSrcReg[1:15], 1'b0})
        else $error("left shift wrong");
    AST_NO_SOURCE: assert property (microWord.busSourceField == 3'h2 && f1 != 4'h7
        && microWord.funcTwoField != 4'h7 && !scratchRead |-> busValue == 16'hffff)
        else $error("idle bus not all ones");
endmodule // mcad_datapath_chk
bind mcad_datapath mcad_datapath_chk chk (.*);

/* test_mcad_datapath.sv */
// Self-checking bench for the microcoded datapath
`timescale 1ns/10ps
`include "mcad_regs.svh"
module test_mcad_datapath
    import mcad_pkg::*;
;
    typedef struct packed {logic [1:0] sel; logic [0:15] val;} mcad_note_t;
    localparam logic [15:0] TMASK = `MCAD_T_FROM_ALU_MASK;
    logic clock = 0, rst_n = 0, skipBit = 0, instrLoad = 0;
    logic [0:3] taskId = 4'h0, pointerBits = 4'h0;
    logic [0:15] memData = 16'h0000, taskSourceData = 16'h0000, a, b, v, x, got;
    logic [0:4] r;
    logic [0:15] shiftSrcReg, operandReg, memAddrReg, instrHoldReg;
    mcad_micro_t wordReq = '0, microWord;
    mcad_note_t notes[$], n;
    int errCount = 0, samplesChecked = 0;
    always #5 clock = ~clock;
    mcad_ctrl_store ctl (.wordReq(wordReq), .microWord(microWord));
    mcad_datapath dut (.clock(clock), .rst_n(rst_n), .microWord(microWord), .taskId(taskId),
        .skipBit(skipBit), .memData(memData), .taskSourceData(taskSourceData),
        .pointerBits(pointerBits), .displaceSignExt(1'b0), .instrLoad(instrLoad),
        .scratchRead(1'b0), .scratchWrite(1'b0), .novelShift(1'b0), .magicShift(1'b0),
        .busValue(), .aluResult(), .aluCarryOut(), .shifterOut(), .nextAddr(),
        .operandReg(operandReg), .shiftSrcReg(shiftSrcReg), .shadowReg(),
        .memAddrReg(memAddrReg), .instrHoldReg(instrHoldReg), .memStart(), .memWrite(),
        .memWriteData(), .savedAluCarry());
    function automatic mcad_micro_t mw(input logic [0:4] s, input logic [0:3] f,
        input logic [0:2] bs, input logic [0:3] f1, input logic [0:3] f2,
        input logic ldT, input logic ldL);
        mw = '{s, f, bs, f1, f2, ldT, ldL, 10'($urandom)};
    endfunction
    function automatic logic [0:15] aluModel(input logic [0:3] c, input logic [0:15] p, q,
        input logic s);
        case (c)
            4'h0: aluModel = p;
            4'h1: aluModel = q;
            4'h2: aluModel = p | q;
            4'h3, 4'hc: aluModel = p & q;
            4'h4: aluModel = p ^ q;
            4'h5: aluModel = p + 16'h0001;
            4'h6: aluModel = p - 16'h0001;
            4'h7: aluModel = p + q;
            4'h8: aluModel = p - q;
            4'h9: aluModel = p - q - 16'h0001;
            4'ha: aluModel = p + q + 16'h0001;
            4'hb: aluModel = p + {15'h0000, s};
            default: aluModel = p & ~q;
        endcase
    endfunction
    task automatic note(input logic [1:0] sel, input logic [0:15] val);
        notes.push_back('{sel, val});
    endtask
    // One word per cycle, driven after the falling edge
    task automatic exec(input mcad_micro_t w);
        wordReq = w;
        @(negedge clock);
    endtask
    // Notes pushed for a word are due right after the following rising edge
    always @(posedge clock) begin
        #1;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.sel)
                2'h0: got = shiftSrcReg;
                2'h1: got = operandReg;
                2'h2: got = memAddrReg;
                default: got = instrHoldReg;
            endcase
            samplesChecked++;
            if (got !== n.val) begin
                errCount++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, n.val);
            end
        end
    end
    task automatic results();
        $display("Counts: compared %0d, mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #20000;
        errCount++;
        results();
    end
    initial begin
        void'($urandom(96));
        repeat (8) @(negedge clock);
        rst_n = 1;
        for (int c = 0; c < 14; c++) begin
            a = $urandom;
            b = $urandom;
            r = $urandom;
            taskId = $urandom;
            skipBit = $urandom;
            taskSourceData = b;
            exec(mw(r, 4'h0, 3'h4, 4'h0, 4'h0, 1'b1, 1'b0));
            taskSourceData = a;
            note(2'h0, aluModel(4'(c), a, b, skipBit));
            note(2'h1, TMASK[c] ? aluModel(4'(c), a, b, skipBit) : a);
            exec(mw(r, 4'(c), 3'h4, 4'h0, 4'h0, 1'b1, 1'b1));
        end
        $display("Test alu done");
        for (int f = 4; f < 7; f++) begin
            v = $urandom;
            r = $urandom;
            taskSourceData = v;
            exec(mw(r, 4'h0, 3'h4, 4'h0, 4'h0, 1'b0, 1'b1));
            exec(mw(r, 4'h0, 3'h1, 4'(f), 4'h0, 1'b0, 1'b0));
            note(2'h0, f == 4 ? {v[1:15], 1'b0} : f == 5 ? {1'b0, v[0:14]}
                : {v[8:15], v[0:7]});
            exec(mw(r, 4'h0, 3'h0, 4'h0, 4'h0, 1'b0, 1'b1));
        end
        $display("Test shifter done");
        a = $urandom;
        taskSourceData = a;
        note(2'h2, a + 16'h0001);
        exec(mw(r, 4'h5, 3'h4, 4'h1, 4'h0, 1'b0, 1'b0));
        for (int s = 0; s < 8; s++) begin
            r = $urandom;
            note(2'h0, s[0] ? 16'h0001 : 16'hffff);
            exec(mw(r, 4'h0, 3'(s), s < 4 ? 4'h7 : 4'h0, s < 4 ? 4'h0 : 4'h7, 1'b0, 1'b1));
        end
        $display("Test constants done");
        pointerBits = $urandom;
        memData = $urandom;
        note(2'h0, {12'hfff, pointerBits});
        exec(mw(r, 4'h0, 3'h6, 4'h0, 4'h0, 1'b0, 1'b1));
        note(2'h0, memData & 16'h0001);
        exec(mw(r, 4'h0, 3'h5, 4'h0, 4'h6, 1'b0, 1'b1));
        note(2'h0, 16'hffff);
        exec(mw(r, 4'h0, 3'h2, 4'h0, 4'h0, 1'b0, 1'b1));
        $display("Test bus done");
        x = $urandom;
        v = $urandom;
        instrLoad = 1;
        taskSourceData = x;
        note(2'h3, x);
        exec(mw(r, 4'h0, 3'h4, 4'h0, 4'h0, 1'b0, 1'b0));
        instrLoad = 0;
        taskSourceData = v;
        exec(mw(r, 4'h0, 3'h4, 4'h0, 4'h0, 1'b0, 1'b1));
        exec(mw({r[0:2], x[1:2]}, 4'h0, 3'h1, 4'h0, 4'h0, 1'b0, 1'b1));
        note(2'h0, v);
        exec(mw({r[0:2], ~x[1:2]}, 4'h0, 3'h0, 4'h0, 4'he, 1'b0, 1'b1));
        exec(mw(r, 4'h0, 3'h2, 4'h0, 4'h0, 1'b0, 1'b0));
        $display("Test cell override done");
        results();
    end
endmodule // test_mcad_datapath
